//--- verilog/aux_timer_block.sv
// Core timer with two auxiliary timers: reload, capture and prescaling.
// Assumes a classic Wishbone master and asynchronous input pins.
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module aux_timer_block
(
   input wire logic clk,
   input wire logic rst,
   input wire timer_pkg::wb_req_type wb_req,
   output var timer_pkg::wb_rsp_type wb_rsp,
   input wire logic [1:0] aux_input_pin,
   input wire logic core_input_pin,
   output logic core_output_pin
);
   import timer_pkg::*;

   logic [15:0] core_ctrl_reg;
   logic [15:0] core_cnt_reg;
   logic [15:0] core_cnt_next;
   logic [2:0] flag_reg;
   logic ack_reg;
   logic [31:0] rdat_reg;
   logic [4:0] div_cnt_reg;
   logic [11:0] pre_cnt_reg;
   logic basic_en;
   logic [2:0] pin_raw;
   logic [2:0] pin_level;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;
   logic [1:0][15:0] aux_ctrl;
   logic [1:0][15:0] aux_cnt;
   logic [1:0] aux_reload;
   logic [1:0] aux_capture;
   logic [1:0] aux_ovf;
   logic [1:0] aux_otl_trig;
   logic req_live;
   logic commit;
   logic core_step;
   logic core_ovf;
   logic otl_rise;
   logic otl_fall;
   logic [2:0] core_mode;
   logic [2:0] core_sel;
   logic [5:0] basic_div;
   logic [2:0] flag_set;

   function automatic logic [11:0] tick_mask(input logic [2:0] s);
      tick_mask = (12'h001 << s) - 12'h001;
   endfunction

   function automatic logic edge_pick(input logic [2:0] s,
      input logic pr, input logic pf, input logic orr, input logic of);
      case (s)
         SEL_PIN_RISE: edge_pick = pr;
         SEL_PIN_FALL: edge_pick = pf;
         SEL_PIN_ANY: edge_pick = pr || pf;
         SEL_OTL_RISE: edge_pick = orr;
         SEL_OTL_FALL: edge_pick = of;
         SEL_OTL_ANY: edge_pick = orr || of;
         default: edge_pick = 1'b0;
      endcase
   endfunction

   function automatic logic [15:0] wmerge(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] sel, input logic [15:0] m);
      logic [15:0] v;
      v = old;
      if (sel[0])
         v[7:0] = d[7:0];
      if (sel[1])
         v[15:8] = d[15:8];
      wmerge = v & m;
   endfunction

   assign req_live = wb_req.cyc && wb_req.stb;
   // Writes land on the edge where the master sees ack high.
   assign commit = req_live && ack_reg;

   function automatic logic wr_hit(input logic [7:0] ofs);
      wr_hit = commit && wb_req.we && (wb_req.adr[7:2] == ofs[7:2]);
   endfunction

   always_comb
   begin
      case (core_ctrl_reg[PS_MSB:PS_LSB])
         PS_DIV4: basic_div = BASIC_DIV4;
         PS_DIV8: basic_div = BASIC_DIV8;
         PS_DIV16: basic_div = BASIC_DIV16;
         PS_DIV32: basic_div = BASIC_DIV32;
         default: basic_div = BASIC_DIV8;
      endcase
   end

   // A shorter division set when the count is at or past its new end ends the period at once with a basic_en pulse.
   assign basic_en = (div_cnt_reg >= 5'(basic_div - 6'h01));

   always_ff @(posedge clk)
   begin
      if (rst)
         div_cnt_reg <= 5'h00;
      else if (basic_en)
         div_cnt_reg <= 5'h00;
      else
         div_cnt_reg <= div_cnt_reg + 5'h01;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         pre_cnt_reg <= 12'h000;
      else if (basic_en)
         pre_cnt_reg <= pre_cnt_reg + 12'h001;
   end

   // One vector keeps every pin index in range for each sampler.
   assign pin_raw = {core_input_pin, aux_input_pin};

   genvar gi;
   for (gi = 0; gi < 3; gi++)
   begin : g_pin
      edge_sampler u_smp
      (
         .clk(clk),
         .rst(rst),
         .pin(pin_raw[gi]),
         .basic_en(basic_en),
         .level(pin_level[gi]),
         .rise(pin_rise[gi]),
         .fall(pin_fall[gi])
      );
   end

   assign core_mode = core_ctrl_reg[MODE_MSB:MODE_LSB];
   assign core_sel = core_ctrl_reg[SEL_MSB:SEL_LSB];

   always_comb
   begin
      core_step = 1'b0;
      if (basic_en && core_ctrl_reg[RUN_BIT])
      begin
         case (core_mode)
            MODE_TIMER: core_step =
               ((pre_cnt_reg & tick_mask(core_sel)) == tick_mask(core_sel));
            MODE_COUNTER: core_step = edge_pick({1'b0, core_sel[1:0]},
               pin_rise[2], pin_fall[2], 1'b0, 1'b0);
            MODE_GATE_LOW: core_step = !pin_level[2] &&
               ((pre_cnt_reg & tick_mask(core_sel)) == tick_mask(core_sel));
            MODE_GATE_HIGH: core_step = pin_level[2] &&
               ((pre_cnt_reg & tick_mask(core_sel)) == tick_mask(core_sel));
            default: core_step = 1'b0;
         endcase
      end
   end

   assign core_ovf = core_step && (core_ctrl_reg[DOWN_BIT] ?
      (core_cnt_reg == CNT_RESET) : (core_cnt_reg == CNT_MAX));
   // Only overflow makes latch edges; bus writes to the latch never do.
   assign otl_rise = core_ovf && !core_ctrl_reg[LATCH_BIT];
   assign otl_fall = core_ovf && core_ctrl_reg[LATCH_BIT];

   for (gi = 0; gi < 2; gi++)
   begin : g_aux
      logic [15:0] ctrl_reg;
      logic [15:0] cnt_reg;
      logic [2:0] mode;
      logic [2:0] sel;
      logic hit;
      logic step;
      logic [7:0] ctrl_ofs;
      logic [7:0] cnt_ofs;

      assign ctrl_ofs = (gi == 0) ? OFS_AUX_A_CTRL : OFS_AUX_B_CTRL;
      assign cnt_ofs = (gi == 0) ? OFS_AUX_A_CNT : OFS_AUX_B_CNT;
      assign mode = ctrl_reg[MODE_MSB:MODE_LSB];
      assign sel = ctrl_reg[SEL_MSB:SEL_LSB];
      assign hit = edge_pick(sel, pin_rise[gi], pin_fall[gi],
         otl_rise, otl_fall);

      always_comb
      begin
         step = 1'b0;
         if (basic_en && ctrl_reg[RUN_BIT])
         begin
            case (mode)
               MODE_TIMER: step =
                  ((pre_cnt_reg & tick_mask(sel)) == tick_mask(sel));
               MODE_COUNTER: step = hit;
               MODE_GATE_LOW: step = !pin_level[gi] &&
                  ((pre_cnt_reg & tick_mask(sel)) == tick_mask(sel));
               MODE_GATE_HIGH: step = pin_level[gi] &&
                  ((pre_cnt_reg & tick_mask(sel)) == tick_mask(sel));
               default: step = 1'b0;
            endcase
         end
      end

      assign aux_reload[gi] = (mode == MODE_RELOAD) && hit;
      assign aux_otl_trig[gi] = aux_reload[gi] && sel[2];
      assign aux_capture[gi] = (mode == MODE_CAPTURE) && edge_pick(
         {1'b0, sel[1:0]}, pin_rise[gi], pin_fall[gi],
         1'b0, 1'b0);
      assign aux_ovf[gi] = step && (ctrl_reg[DOWN_BIT] ?
         (cnt_reg == CNT_RESET) : (cnt_reg == CNT_MAX));
      assign aux_ctrl[gi] = ctrl_reg;
      assign aux_cnt[gi] = cnt_reg;

      always_ff @(posedge clk)
      begin
         if (rst)
            ctrl_reg <= CTRL_RESET;
         else if (wr_hit(ctrl_ofs))
            ctrl_reg <= wmerge(ctrl_reg, wb_req.dat, wb_req.sel,
               AUX_CTRL_MASK);
      end

      // A bus write wins over a capture or count in the same cycle.
      always_ff @(posedge clk)
      begin
         if (rst)
            cnt_reg <= CNT_RESET;
         else if (wr_hit(cnt_ofs))
            cnt_reg <= wmerge(cnt_reg, wb_req.dat, wb_req.sel, CNT_MAX);
         else if (aux_capture[gi])
            cnt_reg <= core_cnt_reg;
         else if (step)
            cnt_reg <= ctrl_reg[DOWN_BIT] ? cnt_reg - 16'h0001 :
               cnt_reg + 16'h0001;
      end
   end

   always_comb
   begin
      core_cnt_next = core_cnt_reg;
      if (wr_hit(OFS_CORE_CNT))
         core_cnt_next = wmerge(core_cnt_reg, wb_req.dat, wb_req.sel,
            CNT_MAX);
      else if (aux_reload[1])
         core_cnt_next = aux_cnt[1];
      else if (aux_reload[0])
         core_cnt_next = aux_cnt[0];
      else if (core_step)
         core_cnt_next = core_ctrl_reg[DOWN_BIT] ?
            core_cnt_reg - 16'h0001 : core_cnt_reg + 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         core_cnt_reg <= CNT_RESET;
      else
         core_cnt_reg <= core_cnt_next;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         core_ctrl_reg <= CTRL_RESET;
      else if (wr_hit(OFS_CORE_CTRL))
         core_ctrl_reg <= wmerge(core_ctrl_reg, wb_req.dat, wb_req.sel,
            CORE_CTRL_MASK);
      else if (core_ovf)
         core_ctrl_reg[LATCH_BIT] <= !core_ctrl_reg[LATCH_BIT];
   end

   assign flag_set[FLAG_A] = aux_reload[0] || aux_capture[0] ||
      aux_ovf[0];
   assign flag_set[FLAG_B] = aux_reload[1] || aux_capture[1] ||
      aux_ovf[1];
   assign flag_set[FLAG_CORE] = core_ovf || (|aux_otl_trig);

   // Setting wins over a same-cycle write-one clear.
   always_ff @(posedge clk)
   begin
      if (rst)
         flag_reg <= FLAGS_RESET;
      else if (wr_hit(OFS_FLAGS) && wb_req.sel[0])
         flag_reg <= (flag_reg & ~wb_req.dat[2:0]) | flag_set;
      else
         flag_reg <= flag_reg | flag_set;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         core_output_pin <= 1'b0;
      else
         core_output_pin <= core_ctrl_reg[OE_BIT] &&
            core_ctrl_reg[LATCH_BIT];
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         ack_reg <= 1'b0;
      else
         ack_reg <= req_live && !ack_reg;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         rdat_reg <= 32'h00000000;
      else if (req_live && !ack_reg)
      begin
         case (wb_req.adr[7:2])
            OFS_CORE_CTRL[7:2]: rdat_reg <= {16'h0000, core_ctrl_reg};
            OFS_AUX_A_CTRL[7:2]: rdat_reg <= {16'h0000, aux_ctrl[0]};
            OFS_AUX_B_CTRL[7:2]: rdat_reg <= {16'h0000, aux_ctrl[1]};
            OFS_CORE_CNT[7:2]: rdat_reg <= {16'h0000, core_cnt_reg};
            OFS_AUX_A_CNT[7:2]: rdat_reg <= {16'h0000, aux_cnt[0]};
            OFS_AUX_B_CNT[7:2]: rdat_reg <= {16'h0000, aux_cnt[1]};
            OFS_FLAGS[7:2]: rdat_reg <= {29'h00000000, flag_reg};
            default: rdat_reg <= 32'h00000000;
         endcase
      end
   end

   assign wb_rsp.ack = ack_reg;
   assign wb_rsp.dat = rdat_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_RELOAD_A: assert property (aux_reload[0] && !aux_reload[1] &&
      !wr_hit(OFS_CORE_CNT) |=> core_cnt_reg == $past(aux_cnt[0]))
      else $error("core timer not reloaded from first auxiliary");
   AST_B_WINS: assert property (aux_reload[0] && aux_reload[1] &&
      !wr_hit(OFS_CORE_CNT) |=> core_cnt_reg == $past(aux_cnt[1]))
      else $error("second auxiliary did not win the reload");
   AST_RELOAD_FLAG: assert property (aux_reload[1]
      |=> flag_reg[FLAG_B])
      else $error("reload did not set the auxiliary flag");
   AST_OTL_CORE_FLAG: assert property (aux_otl_trig[0]
      |=> flag_reg[FLAG_CORE] && flag_reg[FLAG_A])
      else $error("latch reload did not set the core flag");
   AST_OTL_ONLY_OVF: assert property (aux_otl_trig != 2'b00
      |-> core_ovf)
      else $error("latch reload without an overflow");
   AST_RELOAD_HOLD: assert property (g_aux[0].mode == MODE_RELOAD &&
      !wr_hit(OFS_AUX_A_CNT) |=> $stable(aux_cnt[0]))
      else $error("auxiliary counted in reload mode");
   AST_CAPTURE: assert property (aux_capture[1] &&
      !wr_hit(OFS_AUX_B_CNT) |=> aux_cnt[1] == $past(core_cnt_reg)
      && flag_reg[FLAG_B])
      else $error("capture value or flag wrong");
   AST_CAPTURE_HOLD: assert property (g_aux[1].mode == MODE_CAPTURE &&
      !aux_capture[1] && !wr_hit(OFS_AUX_B_CNT) |=> $stable(aux_cnt[1]))
      else $error("auxiliary counted in capture mode");
   AST_BASIC_GAP: assert property (basic_en |=> !basic_en [*3])
      else $error("basic clock faster than divide by four");
   AST_ONLY_BASIC: assert property (!basic_en &&
      !wr_hit(OFS_CORE_CNT) |=> $stable(core_cnt_reg))
      else $error("core timer changed off the basic clock");
   AST_OUT_PIN: assert property (core_ctrl_reg[OE_BIT] == 1'b0
      |=> !core_output_pin)
      else $error("output pin driven while disabled");
   AST_TICK_DIV: assert property (core_step && core_mode == MODE_TIMER
      |-> (pre_cnt_reg & tick_mask(core_sel)) == tick_mask(core_sel))
      else $error("timer step off the prescaled tick");
endmodule
`default_nettype wire

//--- shared/timer_pkg.sv
// Constants, field layout and bus carriers for the auxiliary timer block.
// Assumes a 20 MHz system clock and a classic Wishbone master.
package timer_pkg;
   localparam logic [7:0] OFS_CORE_CTRL = 8'h00;
   localparam logic [7:0] OFS_AUX_A_CTRL = 8'h04;
   localparam logic [7:0] OFS_AUX_B_CTRL = 8'h08;
   localparam logic [7:0] OFS_CORE_CNT = 8'h0c;
   localparam logic [7:0] OFS_AUX_A_CNT = 8'h10;
   localparam logic [7:0] OFS_AUX_B_CNT = 8'h14;
   localparam logic [7:0] OFS_FLAGS = 8'h18;
   localparam int SEL_MSB = 2;
   localparam int SEL_LSB = 0;
   localparam int MODE_MSB = 5;
   localparam int MODE_LSB = 3;
   localparam int RUN_BIT = 6;
   localparam int DOWN_BIT = 7;
   localparam int OE_BIT = 9;
   localparam int LATCH_BIT = 10;
   localparam int PS_MSB = 12;
   localparam int PS_LSB = 11;
   localparam int FLAG_A = 0;
   localparam int FLAG_CORE = 1;
   localparam int FLAG_B = 2;
   localparam logic [15:0] CORE_CTRL_MASK = 16'h1eff;
   localparam logic [15:0] AUX_CTRL_MASK = 16'h00ff;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [2:0] FLAGS_RESET = 3'h0;
   localparam logic [2:0] MODE_TIMER = 3'h0;
   localparam logic [2:0] MODE_COUNTER = 3'h1;
   localparam logic [2:0] MODE_GATE_LOW = 3'h2;
   localparam logic [2:0] MODE_GATE_HIGH = 3'h3;
   localparam logic [2:0] MODE_RELOAD = 3'h4;
   localparam logic [2:0] MODE_CAPTURE = 3'h5;
   localparam logic [2:0] SEL_PIN_RISE = 3'h1;
   localparam logic [2:0] SEL_PIN_FALL = 3'h2;
   localparam logic [2:0] SEL_PIN_ANY = 3'h3;
   localparam logic [2:0] SEL_OTL_RISE = 3'h5;
   localparam logic [2:0] SEL_OTL_FALL = 3'h6;
   localparam logic [2:0] SEL_OTL_ANY = 3'h7;
   localparam logic [1:0] PS_DIV4 = 2'h1;
   localparam logic [1:0] PS_DIV8 = 2'h0;
   localparam logic [1:0] PS_DIV16 = 2'h3;
   localparam logic [1:0] PS_DIV32 = 2'h2;
   localparam logic [5:0] BASIC_DIV4 = 6'h04;
   localparam logic [5:0] BASIC_DIV8 = 6'h08;
   localparam logic [5:0] BASIC_DIV16 = 6'h10;
   localparam logic [5:0] BASIC_DIV32 = 6'h20;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_type;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_type;
endpackage

//--- verilog/edge_sampler.sv
// Input pin synchroniser and basic clock sampler with edge flags.
// Assumes basic_en is a one-cycle pulse on the clk domain.
`timescale 1ns/1ns
`default_nettype none
module edge_sampler
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   input wire logic basic_en,
   output logic level,
   output logic rise,
   output logic fall
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic stable_reg;
   logic sample_reg;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A level is accepted only once the two later stages agree.
   always_ff @(posedge clk)
   begin
      if (rst)
         stable_reg <= 1'b0;
      else if (s2_reg == s3_reg)
         stable_reg <= s3_reg;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         sample_reg <= 1'b0;
      else if (basic_en)
         sample_reg <= stable_reg;
   end

   // Edges compare this basic sample with the last one, so they fire once.
   assign level = sample_reg;
   assign rise = basic_en && stable_reg && !sample_reg;
   assign fall = basic_en && !stable_reg && sample_reg;
endmodule
`default_nettype wire

//--- test/pin_source.sv
// Far-side model that drives the three timer input pins.
// Assumes the bench asks for levels; the model keeps each level long enough.
`timescale 1ns/1ns
`default_nettype none
module pin_source
#(
   parameter int HOLD = 40
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] want,
   output logic [2:0] pins
);
   int held [3];

   // The pins are always driven, so the block only ever sees them as inputs.
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 3; i++)
      begin
         if (rst)
         begin
            pins[i] <= 1'b0;
            held[i] <= 0;
         end
         else if (want[i] != pins[i] && held[i] >= HOLD)
         begin
            pins[i] <= want[i];
            held[i] <= 0;
         end
         else if (held[i] < HOLD)
         begin
            held[i] <= held[i] + 1;
         end
      end
   end
endmodule
`default_nettype wire

//--- test/aux_timer_reload_capture_prescale_bench.sv
// Self-checking bench for the auxiliary timer block.
// Assumes the pin source model drives all three timer input pins.
`timescale 1ns/1ns
`default_nettype none
module aux_timer_reload_capture_prescale_bench;
   import timer_pkg::*;
   typedef struct packed {
      logic u;
      logic [2:0] m;
      logic [2:0] s;
      logic v;
      logic hit;
   } row_type;
   typedef struct packed {
      logic [1:0] p;
      logic [2:0] s;
      logic [5:0] d;
   } ps_type;
   // Capture rows keep select bit 2 clear.
   localparam row_type ROWS [12] = '{
      '{1'b0, MODE_CAPTURE, SEL_PIN_RISE, 1'b1, 1'b1},
      '{1'b0, MODE_CAPTURE, SEL_PIN_RISE, 1'b0, 1'b0},
      '{1'b0, MODE_CAPTURE, SEL_PIN_FALL, 1'b1, 1'b0},
      '{1'b0, MODE_CAPTURE, SEL_PIN_FALL, 1'b0, 1'b1},
      '{1'b0, MODE_CAPTURE, SEL_PIN_ANY, 1'b1, 1'b1},
      '{1'b0, MODE_RELOAD, SEL_PIN_ANY, 1'b0, 1'b1},
      '{1'b0, MODE_RELOAD, SEL_PIN_RISE, 1'b1, 1'b1},
      '{1'b0, MODE_RELOAD, SEL_PIN_FALL, 1'b0, 1'b1},
      '{1'b1, MODE_CAPTURE, SEL_PIN_ANY, 1'b1, 1'b1},
      '{1'b1, MODE_RELOAD, SEL_PIN_FALL, 1'b0, 1'b1},
      '{1'b1, MODE_RELOAD, SEL_PIN_RISE, 1'b1, 1'b1},
      '{1'b1, MODE_RELOAD, SEL_PIN_RISE, 1'b0, 1'b0}};
   localparam ps_type PS_ROWS [5] = '{
      '{PS_DIV4, 3'h0, 6'h04}, '{PS_DIV8, 3'h0, 6'h08},
      '{PS_DIV16, 3'h0, 6'h10}, '{PS_DIV32, 3'h0, 6'h20},
      '{PS_DIV4, 3'h3, 6'h20}};
   logic clk;
   logic rst;
   wb_req_type req;
   wb_rsp_type rsp;
   logic [2:0] want;
   logic [2:0] pins;
   logic core_output_pin;
   logic [7:0] ca;
   logic [15:0] c, r, fl, q;
   logic cap, rel;
   int e;
   int fails = 0;
   int check_count = 0;

   aux_timer_block u_aux_timer_block (.clk(clk), .rst(rst), .wb_req(req),
      .wb_rsp(rsp), .aux_input_pin(pins[1:0]), .core_input_pin(pins[2]),
      .core_output_pin(core_output_pin));
   pin_source #(.HOLD(40)) u_pin_source (.clk(clk), .rst(rst),
      .want(want), .pins(pins));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, lo, hi);
      check_count++;
      if (((got >= lo) && (got <= hi)) !== 1'b1)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h..%h", $time, got,
            lo, hi);
      end
   endtask

   // One classic cycle; the request stands until ack is sampled high.
   // Only the watchdog ends a wait for an answer that never comes.
   task automatic bus(input logic [7:0] a, input logic w,
      input logic [15:0] d, output logic [15:0] qq);
      req <= '{1'b1, 1'b1, w, a, 4'h3, {16'h0, d}};
      @(posedge clk);
      while (rsp.ack !== 1'b1)
         @(posedge clk);
      qq = rsp.dat[15:0];
      req <= '0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] x;
      bus(a, 1'b1, d, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] x);
      bus(a, 1'b0, 16'h0, x);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] lo, hi);
      logic [15:0] x;
      bus(a, 1'b0, 16'h0, x);
      chk(x, lo, hi);
   endtask

   function automatic logic [15:0] cv(input logic [2:0] m, s,
      input logic run, input logic [15:0] x);
      return x | {9'h0, run, m, s};
   endfunction

   // Core runs from 0xffff at the fastest rate while toggle edges reload it.
   task automatic otl(input logic [2:0] sa, input logic [2:0] sb,
      input logic [15:0] vb, lo, hi, input logic [2:0] fm);
      logic [15:0] x;
      wr(OFS_CORE_CTRL, 16'h0);
      wr(OFS_CORE_CNT, 16'hffff);
      wr(OFS_AUX_A_CNT, 16'hfffe);
      wr(OFS_AUX_B_CNT, vb);
      wr(OFS_AUX_A_CTRL, cv(MODE_RELOAD, sa, 1'b1, 16'h0));
      wr(OFS_AUX_B_CTRL, cv(MODE_RELOAD, sb, 1'b1, 16'h0));
      wr(OFS_FLAGS, 16'h7);
      wr(OFS_CORE_CTRL, 16'h0400);
      wr(OFS_CORE_CTRL, 16'h0);
      repeat (40) @(posedge clk);
      rdc(OFS_CORE_CNT, 16'hffff, 16'hffff);
      rdc(OFS_FLAGS, 16'h0, 16'h0);
      wr(OFS_CORE_CTRL, cv(MODE_TIMER, 3'h0, 1'b1,
         16'h0200 | {3'h0, PS_DIV4, 11'h0}));
      repeat (200) @(posedge clk);
      rd(OFS_CORE_CTRL, x);
      wr(OFS_CORE_CTRL, x & 16'hffbf);
      rdc(OFS_CORE_CNT, lo, hi);
      rd(OFS_FLAGS, x);
      chk(x & {13'h0, fm}, {13'h0, fm}, {13'h0, fm});
      rd(OFS_CORE_CTRL, x);
      chk({15'h0, core_output_pin}, {15'h0, x[LATCH_BIT]},
         {15'h0, x[LATCH_BIT]});
   endtask

   initial
   begin
      rst = 1'b1;
      req = '0;
      want = 3'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++)
         rdc(8'(a * 4), 16'h0, 16'h0);
      wr(8'h1c, 16'hffff);
      rdc(8'h1c, 16'h0, 16'h0);
      for (int i = 0; i < 12; i++)
      begin
         ca = ROWS[i].u ? OFS_AUX_B_CNT : OFS_AUX_A_CNT;
         fl = ROWS[i].u ? 16'h4 : 16'h1;
         c = 16'h1000 + 16'(i);
         r = 16'h2000 + 16'(i);
         cap = ROWS[i].hit && ROWS[i].m == MODE_CAPTURE;
         rel = ROWS[i].hit && ROWS[i].m == MODE_RELOAD;
         wr(OFS_CORE_CNT, c);
         wr(ca, r);
         wr(ROWS[i].u ? OFS_AUX_B_CTRL : OFS_AUX_A_CTRL,
            cv(ROWS[i].m, ROWS[i].s, 1'b1, 16'h0));
         wr(OFS_FLAGS, 16'h7);
         want[ROWS[i].u] <= ROWS[i].v;
         repeat (150) @(posedge clk);
         rdc(OFS_CORE_CNT, rel ? r : c, rel ? r : c);
         rdc(ca, cap ? c : r, cap ? c : r);
         fl = ROWS[i].hit ? fl : 16'h0;
         rdc(OFS_FLAGS, fl, fl);
      end
      otl(SEL_OTL_ANY, 3'h0, 16'h0, 16'hfffe, 16'hffff, 3'h3);
      otl(SEL_OTL_RISE, 3'h0, 16'h0, 16'h0000, 16'h0100, 3'h3);
      otl(SEL_OTL_FALL, 3'h0, 16'h0, 16'h0000, 16'h0100, 3'h2);
      otl(SEL_OTL_ANY, SEL_OTL_ANY, 16'h8000, 16'h8000, 16'h8100,
         3'h6);
      wr(OFS_CORE_CTRL, 16'h0);
      wr(OFS_CORE_CNT, 16'h0);
      wr(OFS_CORE_CTRL, cv(MODE_COUNTER, SEL_PIN_RISE, 1'b1, 16'h0));
      for (int k = 0; k < 6; k++)
      begin
         want[2] <= ~want[2];
         repeat (60) @(posedge clk);
      end
      rdc(OFS_CORE_CNT, 16'h3, 16'h3);
      for (int j = 0; j < 5; j++)
      begin
         e = 512 / PS_ROWS[j].d;
         wr(OFS_CORE_CTRL, 16'h0);
         wr(OFS_CORE_CNT, 16'h0);
         wr(OFS_CORE_CTRL, cv(MODE_TIMER, PS_ROWS[j].s, 1'b1,
            {3'h0, PS_ROWS[j].p, 11'h0}));
         repeat (512) @(posedge clk);
         wr(OFS_CORE_CTRL, 16'h0);
         rdc(OFS_CORE_CNT, 16'(e - 2), 16'(e + 2));
      end
      // A second reset in mid-run must clear the count it left behind.
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(OFS_CORE_CNT, 16'h0, 16'h0);
      close_out();
   end

   initial
   begin
      repeat (40000) @(posedge clk);
      fails++;
      close_out();
   end
endmodule
`default_nettype wire
